// ---- rtl/cpu_sys_pkg.sv ----
/*
  constants, field positions, operation codes and helper functions shared by the
  system register group, its stack sequencer, clock prescaler and address extension.
  assumes a single 50 MHz clock and a synchronous active-high reset in every user.
*/
// Behaviour
// - page pointer holds page number in bits 7:2
// - page pointer bits 1:0 always read zero
// - page pointer kept until software writes again
// - mode register resets to e0h
// - mode bit 7 selects internal system stack
// - mode bit 6 selects internal user stack
// - mode bit 5 halves the oscillator clock
// - mode bits 4:2 hold clock prescale setting
// - mode bit 1 enables bus request pin
// - mode bit 0 floats external bus lines
// - float leaves general i/o lines untouched
// - push predecrements, pop postincrements, words by two
// - pop leaves vacated stack bytes unchanged
// - interrupt pushes pc, flags, optionally code segment
// - call pushes pc; segment call adds segment
// - returns pop what their counterpart pushed
// - internal stack uses pointer low byte only
// - address space is 4 mbyte, 64 segments
// - four data page, three segment registers, page 21
// - top two virtual bits pick data page register
// - code segment forms six top program bits

package cpu_sys_pkg;

  // register file addresses
  localparam logic [7:0] ADDR_PAGE_POINTER = 8'hea;
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'heb;
  localparam logic [7:0] ADDR_USER_SP_HIGH = 8'hec;
  localparam logic [7:0] ADDR_USER_SP_LOW = 8'hed;
  localparam logic [7:0] ADDR_SYS_SP_HIGH = 8'hee;
  localparam logic [7:0] ADDR_SYS_SP_LOW = 8'hef;
  localparam logic [7:0] ADDR_DATA_PAGE_0 = 8'hf0;
  localparam logic [7:0] ADDR_CODE_SEGMENT = 8'hf4;
  localparam logic [7:0] ADDR_INT_SEGMENT = 8'hf8;
  localparam logic [7:0] ADDR_DMA_SEGMENT = 8'hfc;
  localparam logic [5:0] MMU_PAGE = 6'h15;

  // field layout and reset values
  localparam logic [7:0] MODE_RESET = 8'he0;
  localparam logic [5:0] PAGE_RESET = 6'h00;
  localparam logic [5:0] SEG_RESET = 6'h00;
  localparam logic [7:0] DPR_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam int MODE_SYS_STACK_BIT = 7;
  localparam int MODE_USER_STACK_BIT = 6;
  localparam int MODE_HALVE_BIT = 5;
  localparam int MODE_PRS_HI = 4;
  localparam int MODE_PRS_LO = 2;
  localparam int MODE_BRQ_BIT = 1;
  localparam int MODE_FLOAT_BIT = 0;
  localparam int PAGE_HI = 7;
  localparam int PAGE_LO = 2;
  localparam int SEG_BITS = 6;
  localparam int DPR_BITS = 8;
  localparam int VIRT_BITS = 16;
  localparam int PHYS_BITS = 22;
  localparam int PAGE_OFS_BITS = 14;
  localparam int FLOAT_LINES = 32;
  localparam int PRS_BITS = 3;

  // stack operations
  localparam int OP_BITS = 4;
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_PUSH_BYTE = 4'h1;
  localparam logic [3:0] OP_PUSH_WORD = 4'h2;
  localparam logic [3:0] OP_POP_BYTE = 4'h3;
  localparam logic [3:0] OP_POP_WORD = 4'h4;
  localparam logic [3:0] OP_INTR = 4'h5;
  localparam logic [3:0] OP_CALL = 4'h6;
  localparam logic [3:0] OP_CALL_SEG = 4'h7;
  localparam logic [3:0] OP_RET = 4'h8;
  localparam logic [3:0] OP_RET_SEG = 4'h9;
  localparam logic [3:0] OP_IRET = 4'ha;

  // address extension access kinds
  localparam logic [1:0] ACC_DATA = 2'h0;
  localparam logic [1:0] ACC_PROG = 2'h1;
  localparam logic [1:0] ACC_INTR = 2'h2;
  localparam logic [1:0] ACC_DMA = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSH = 5'b00010,
    ST_POP = 5'b00100,
    ST_CAP = 5'b01000,
    ST_DONE = 5'b10000
  } stack_state_type;

  // step a stack pointer; an internal stack moves only its low byte
  function automatic logic [15:0] step_ptr(input logic [15:0] sp, input logic internal,
                                           input logic down);
    logic [7:0] lo;
    lo = down ? sp[7:0] - 8'h01 : sp[7:0] + 8'h01;
    if (internal) begin
      step_ptr = {sp[15:8], lo};
    end else begin
      step_ptr = down ? sp - 16'h0001 : sp + 16'h0001;
    end
  endfunction : step_ptr

  // byte address driven to the stack memory
  function automatic logic [15:0] stack_addr(input logic [15:0] sp, input logic internal);
    stack_addr = internal ? {8'h00, sp[7:0]} : sp;
  endfunction : stack_addr

endpackage : cpu_sys_pkg

// ---- rtl/prescale_divider.sv ----
/*
  internal cpu clock enable generator: optional halving of the oscillator rate,
  then division by the prescale field plus one.
  assumes the oscillator input is clk_in itself; the output is a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none

module prescale_divider (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic osc_halve_enable_in,
  input wire logic [cpu_sys_pkg::PRS_BITS-1:0] clock_prescale_field_in,
  output logic internal_cpu_clock_en_out
);
  import cpu_sys_pkg::*;

  logic half_r;
  logic half_nxt;
  logic [PRS_BITS-1:0] cnt_r;
  logic [PRS_BITS-1:0] cnt_nxt;
  logic en_nxt;
  logic base_en;

  // halve stage then a counter that wraps at the field value
  always_comb begin
    half_nxt = ~half_r;
    base_en = osc_halve_enable_in ? half_r : 1'b1;
    cnt_nxt = cnt_r;
    en_nxt = 1'b0;
    if (base_en) begin
      if (cnt_r >= clock_prescale_field_in) begin
        cnt_nxt = '0;
        en_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      half_r <= 1'b0;
      cnt_r <= '0;
      internal_cpu_clock_en_out <= 1'b0;
    end else begin
      half_r <= half_nxt;
      cnt_r <= cnt_nxt;
      internal_cpu_clock_en_out <= en_nxt;
    end
  end

endmodule : prescale_divider

`default_nettype wire

// ---- rtl/addr_extend.sv ----
/*
  address extension: four data page registers and three segment registers on
  register page 21, and the 16-to-22 bit translation they drive.
  assumes register writes arrive as one-cycle strobes with the selected page.
*/
`timescale 1ns/1ps
`default_nettype none

module addr_extend (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [5:0] page_in,
  input wire logic csr_load_in,
  input wire logic [cpu_sys_pkg::SEG_BITS-1:0] csr_load_data_in,
  input wire logic [cpu_sys_pkg::VIRT_BITS-1:0] virt_addr_in,
  input wire logic [1:0] access_kind_in,
  output logic [cpu_sys_pkg::SEG_BITS-1:0] code_segment_out,
  output logic [7:0] rdata_out,
  output logic hit_out,
  output logic [cpu_sys_pkg::PHYS_BITS-1:0] phys_addr_out
);
  import cpu_sys_pkg::*;

  logic [DPR_BITS-1:0] data_page_regs [4];
  logic [SEG_BITS-1:0] int_seg_r;
  logic [SEG_BITS-1:0] dma_seg_r;
  logic mmu_sel;

  assign mmu_sel = (page_in == MMU_PAGE);

  // register read mux, upper segment bits read zero
  always_comb begin
    hit_out = mmu_sel;
    rdata_out = 8'h00;
    if (mmu_sel && reg_addr_in[7:2] == ADDR_DATA_PAGE_0[7:2]) begin
      rdata_out = data_page_regs[reg_addr_in[1:0]];
    end else if (mmu_sel && reg_addr_in == ADDR_CODE_SEGMENT) begin
      rdata_out = {2'b00, code_segment_out};
    end else if (mmu_sel && reg_addr_in == ADDR_INT_SEGMENT) begin
      rdata_out = {2'b00, int_seg_r};
    end else if (mmu_sel && reg_addr_in == ADDR_DMA_SEGMENT) begin
      rdata_out = {2'b00, dma_seg_r};
    end else begin
      hit_out = 1'b0;
    end
  end

  // register writes; a restore from the stack wins over software
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 4; i++) begin
        data_page_regs[i] <= DPR_RESET;
      end
      code_segment_out <= SEG_RESET;
      int_seg_r <= SEG_RESET;
      dma_seg_r <= SEG_RESET;
    end else begin
      if (reg_wr_in && mmu_sel && reg_addr_in[7:2] == ADDR_DATA_PAGE_0[7:2]) begin
        data_page_regs[reg_addr_in[1:0]] <= reg_wdata_in;
      end
      if (csr_load_in) begin
        code_segment_out <= csr_load_data_in;
      end else if (reg_wr_in && mmu_sel && reg_addr_in == ADDR_CODE_SEGMENT) begin
        code_segment_out <= reg_wdata_in[SEG_BITS-1:0];
      end
      if (reg_wr_in && mmu_sel && reg_addr_in == ADDR_INT_SEGMENT) begin
        int_seg_r <= reg_wdata_in[SEG_BITS-1:0];
      end
      if (reg_wr_in && mmu_sel && reg_addr_in == ADDR_DMA_SEGMENT) begin
        dma_seg_r <= reg_wdata_in[SEG_BITS-1:0];
      end
    end
  end

  // translation, registered: one cycle from virtual to physical
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phys_addr_out <= '0;
    end else begin
      case (access_kind_in)
        ACC_DATA: phys_addr_out <= {data_page_regs[virt_addr_in[15:14]],
                                    virt_addr_in[PAGE_OFS_BITS-1:0]};
        ACC_PROG: phys_addr_out <= {code_segment_out, virt_addr_in};
        ACC_INTR: phys_addr_out <= {int_seg_r, virt_addr_in};
        ACC_DMA: phys_addr_out <= {dma_seg_r, virt_addr_in};
        default: phys_addr_out <= '0;
      endcase
    end
  end

endmodule : addr_extend

`default_nettype wire

// ---- rtl/cpu_system_mode_stack_regs.sv ----
/*
  system register group: page pointer, mode register, user and system stack
  pointers, the stack push/pop sequencer, bus float and bus request gating.
  assumes a byte-wide register port, a byte-wide stack memory read combinationally
  while mem_re_out is high, and instructions issued as one-cycle operation codes.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_system_mode_stack_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic set_page_in,
  input wire logic [5:0] page_in,
  output logic [5:0] page_select_out,
  input wire logic [cpu_sys_pkg::OP_BITS-1:0] stack_op_in,
  input wire logic stack_user_in,
  input wire logic [15:0] push_data_in,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] flags_in,
  input wire logic segment_push_enable_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_we_out,
  output logic mem_re_out,
  output logic stack_internal_out,
  output logic stack_busy_out,
  output logic stack_done_out,
  output logic [31:0] pop_data_out,
  output logic system_stack_internal_sel_out,
  output logic user_stack_internal_sel_out,
  output logic osc_halve_enable_out,
  output logic [cpu_sys_pkg::PRS_BITS-1:0] clock_prescale_field_out,
  output logic bus_request_enable_out,
  output logic bus_float_enable_out,
  input wire logic bus_request_pin_in,
  output logic bus_request_out,
  input wire logic [cpu_sys_pkg::FLOAT_LINES-1:0] ext_mem_line_mask_in,
  output logic [cpu_sys_pkg::FLOAT_LINES-1:0] ext_line_float_out,
  output logic strobe_float_out,
  output logic internal_cpu_clock_en_out,
  input wire logic [cpu_sys_pkg::VIRT_BITS-1:0] virt_addr_in,
  input wire logic [1:0] access_kind_in,
  output logic [cpu_sys_pkg::PHYS_BITS-1:0] phys_addr_out
);
  import cpu_sys_pkg::*;

  // register group state
  logic [5:0] page_r;
  logic [5:0] page_nxt;
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [15:0] usp_r;
  logic [15:0] usp_nxt;
  logic [15:0] ssp_r;
  logic [15:0] ssp_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // stack sequencer state
  stack_state_type state_r;
  stack_state_type state_nxt;
  logic user_r;
  logic user_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [31:0] push_q_r;
  logic [31:0] push_q_nxt;
  logic [31:0] pop_q_r;
  logic [31:0] pop_q_nxt;
  logic restore_r;
  logic restore_nxt;
  logic [15:0] maddr_r;
  logic [15:0] maddr_nxt;
  logic [7:0] mwdata_r;
  logic [7:0] mwdata_nxt;
  logic mwe_r;
  logic mwe_nxt;
  logic mre_r;
  logic mre_nxt;
  logic done_r;
  logic done_nxt;
  logic [31:0] pop_data_r;
  logic [31:0] pop_data_nxt;

  // pin-side registered outputs
  logic brq_r;
  logic [FLOAT_LINES-1:0] float_r;
  logic strobe_float_r;
  logic internal_r;
  logic busy_r;

  // shared combinational terms
  logic [15:0] cur_sp;
  logic [15:0] new_sp;
  logic cur_internal;
  logic csr_load;
  logic [SEG_BITS-1:0] code_segment;
  logic [7:0] mmu_rdata;
  logic mmu_hit;
  logic sw_write;

  assign cur_sp = user_r ? usp_r : ssp_r;
  assign cur_internal = user_r ? mode_r[MODE_USER_STACK_BIT]
                               : mode_r[MODE_SYS_STACK_BIT];
  assign sw_write = reg_wr_in && (state_r == ST_IDLE);

  // software register access, page pointer and register readback
  always_comb begin
    page_nxt = page_r;
    mode_nxt = mode_r;
    rdata_nxt = rdata_r;
    if (set_page_in) begin
      page_nxt = page_in;
    end else if (reg_wr_in && reg_addr_in == ADDR_PAGE_POINTER) begin
      page_nxt = reg_wdata_in[PAGE_HI:PAGE_LO];
    end
    if (reg_wr_in && reg_addr_in == ADDR_MODE_CONTROL) begin
      mode_nxt = reg_wdata_in;
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_PAGE_POINTER: rdata_nxt = {page_r, 2'b00};
        ADDR_MODE_CONTROL: rdata_nxt = mode_r;
        ADDR_USER_SP_HIGH: rdata_nxt = usp_r[15:8];
        ADDR_USER_SP_LOW: rdata_nxt = usp_r[7:0];
        ADDR_SYS_SP_HIGH: rdata_nxt = ssp_r[15:8];
        ADDR_SYS_SP_LOW: rdata_nxt = ssp_r[7:0];
        default: rdata_nxt = mmu_hit ? mmu_rdata : 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      page_r <= PAGE_RESET;
      mode_r <= MODE_RESET;
      rdata_r <= 8'h00;
    end else begin
      page_r <= page_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // stack sequencer: loads a byte queue, then writes one byte a cycle or reads one byte every two cycles
  always_comb begin
    state_nxt = state_r;
    user_nxt = user_r;
    cnt_nxt = cnt_r;
    push_q_nxt = push_q_r;
    pop_q_nxt = pop_q_r;
    restore_nxt = restore_r;
    maddr_nxt = maddr_r;
    mwdata_nxt = mwdata_r;
    mwe_nxt = 1'b0;
    mre_nxt = 1'b0;
    done_nxt = 1'b0;
    pop_data_nxt = pop_data_r;
    usp_nxt = usp_r;
    ssp_nxt = ssp_r;
    csr_load = 1'b0;
    new_sp = cur_sp;
    if (sw_write) begin
      case (reg_addr_in)
        ADDR_USER_SP_HIGH: usp_nxt[15:8] = reg_wdata_in;
        ADDR_USER_SP_LOW: usp_nxt[7:0] = reg_wdata_in;
        ADDR_SYS_SP_HIGH: ssp_nxt[15:8] = reg_wdata_in;
        ADDR_SYS_SP_LOW: ssp_nxt[7:0] = reg_wdata_in;
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: begin
        user_nxt = 1'b0;
        restore_nxt = 1'b0;
        pop_q_nxt = 32'h0000_0000;
        push_q_nxt = 32'h0000_0000;
        cnt_nxt = 3'd0;
        state_nxt = ST_IDLE;
        case (stack_op_in)
          OP_PUSH_BYTE: begin
            user_nxt = stack_user_in;
            push_q_nxt = {24'h00_0000, push_data_in[7:0]};
            cnt_nxt = 3'd1;
            state_nxt = ST_PUSH;
          end
          OP_PUSH_WORD: begin
            user_nxt = stack_user_in;
            push_q_nxt = {16'h0000, push_data_in};
            cnt_nxt = 3'd2;
            state_nxt = ST_PUSH;
          end
          OP_POP_BYTE: begin
            user_nxt = stack_user_in;
            cnt_nxt = 3'd1;
            state_nxt = ST_POP;
          end
          OP_POP_WORD: begin
            user_nxt = stack_user_in;
            cnt_nxt = 3'd2;
            state_nxt = ST_POP;
          end
          OP_INTR: begin
            if (segment_push_enable_in) begin
              push_q_nxt = {flags_in, pc_in, 2'b00, code_segment};
              cnt_nxt = 3'd4;
            end else begin
              push_q_nxt = {8'h00, flags_in, pc_in};
              cnt_nxt = 3'd3;
            end
            state_nxt = ST_PUSH;
          end
          OP_CALL: begin
            push_q_nxt = {16'h0000, pc_in};
            cnt_nxt = 3'd2;
            state_nxt = ST_PUSH;
          end
          OP_CALL_SEG: begin
            push_q_nxt = {8'h00, pc_in, 2'b00, code_segment};
            cnt_nxt = 3'd3;
            state_nxt = ST_PUSH;
          end
          OP_RET: begin
            cnt_nxt = 3'd2;
            state_nxt = ST_POP;
          end
          OP_RET_SEG: begin
            cnt_nxt = 3'd3;
            restore_nxt = 1'b1;
            state_nxt = ST_POP;
          end
          OP_IRET: begin
            cnt_nxt = segment_push_enable_in ? 3'd4 : 3'd3;
            restore_nxt = segment_push_enable_in;
            state_nxt = ST_POP;
          end
          default: state_nxt = ST_IDLE;
        endcase
      end
      ST_PUSH: begin
        new_sp = step_ptr(cur_sp, cur_internal, 1'b1);
        maddr_nxt = stack_addr(new_sp, cur_internal);
        mwdata_nxt = push_q_r[7:0];
        mwe_nxt = 1'b1;
        push_q_nxt = {8'h00, push_q_r[31:8]};
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1) begin
          state_nxt = ST_DONE;
        end
      end
      ST_POP: begin
        maddr_nxt = stack_addr(cur_sp, cur_internal);
        mre_nxt = 1'b1;
        new_sp = step_ptr(cur_sp, cur_internal, 1'b0);
        state_nxt = ST_CAP;
      end
      ST_CAP: begin
        pop_q_nxt = {pop_q_r[23:0], mem_rdata_in};
        cnt_nxt = cnt_r - 3'd1;
        if (cnt_r == 3'd1) begin
          csr_load = restore_r;
          state_nxt = ST_DONE;
        end else begin
          state_nxt = ST_POP;
        end
      end
      ST_DONE: begin
        done_nxt = 1'b1;
        pop_data_nxt = pop_q_r;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    // engine pointer update; no software stack pointer write lands outside idle
    if (state_r == ST_PUSH || state_r == ST_POP) begin
      if (user_r) begin
        usp_nxt = new_sp;
      end else begin
        ssp_nxt = new_sp;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      user_r <= 1'b0;
      cnt_r <= 3'd0;
      push_q_r <= 32'h0000_0000;
      pop_q_r <= 32'h0000_0000;
      restore_r <= 1'b0;
      maddr_r <= 16'h0000;
      mwdata_r <= 8'h00;
      mwe_r <= 1'b0;
      mre_r <= 1'b0;
      done_r <= 1'b0;
      pop_data_r <= 32'h0000_0000;
      usp_r <= SP_RESET;
      ssp_r <= SP_RESET;
    end else begin
      state_r <= state_nxt;
      user_r <= user_nxt;
      cnt_r <= cnt_nxt;
      push_q_r <= push_q_nxt;
      pop_q_r <= pop_q_nxt;
      restore_r <= restore_nxt;
      maddr_r <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      mwe_r <= mwe_nxt;
      mre_r <= mre_nxt;
      done_r <= done_nxt;
      pop_data_r <= pop_data_nxt;
      usp_r <= usp_nxt;
      ssp_r <= ssp_nxt;
    end
  end

  // bus request gating and external bus float, general i/o lines masked out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      brq_r <= 1'b0;
      float_r <= '0;
      strobe_float_r <= 1'b0;
      internal_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      brq_r <= bus_request_pin_in & mode_r[MODE_BRQ_BIT];
      float_r <= ext_mem_line_mask_in & {FLOAT_LINES{mode_r[MODE_FLOAT_BIT]}};
      strobe_float_r <= mode_r[MODE_FLOAT_BIT];
      internal_r <= cur_internal;
      busy_r <= state_nxt != ST_IDLE;
    end
  end

  prescale_divider u_prescale (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .osc_halve_enable_in(mode_r[MODE_HALVE_BIT]),
    .clock_prescale_field_in(mode_r[MODE_PRS_HI:MODE_PRS_LO]),
    .internal_cpu_clock_en_out(internal_cpu_clock_en_out)
  );

  addr_extend u_addr_extend (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in),
    .page_in(page_r),
    .csr_load_in(csr_load),
    .csr_load_data_in(mem_rdata_in[SEG_BITS-1:0]),
    .virt_addr_in(virt_addr_in),
    .access_kind_in(access_kind_in),
    .code_segment_out(code_segment),
    .rdata_out(mmu_rdata),
    .hit_out(mmu_hit),
    .phys_addr_out(phys_addr_out)
  );

  // outputs straight from flip-flops
  assign reg_rdata_out = rdata_r;
  assign page_select_out = page_r;
  assign mem_addr_out = maddr_r;
  assign mem_wdata_out = mwdata_r;
  assign mem_we_out = mwe_r;
  assign mem_re_out = mre_r;
  assign stack_internal_out = internal_r;
  assign stack_busy_out = busy_r;
  assign stack_done_out = done_r;
  assign pop_data_out = pop_data_r;
  assign system_stack_internal_sel_out = mode_r[MODE_SYS_STACK_BIT];
  assign user_stack_internal_sel_out = mode_r[MODE_USER_STACK_BIT];
  assign osc_halve_enable_out = mode_r[MODE_HALVE_BIT];
  assign clock_prescale_field_out = mode_r[MODE_PRS_HI:MODE_PRS_LO];
  assign bus_request_enable_out = mode_r[MODE_BRQ_BIT];
  assign bus_float_enable_out = mode_r[MODE_FLOAT_BIT];
  assign bus_request_out = brq_r;
  assign ext_line_float_out = float_r;
  assign strobe_float_out = strobe_float_r;

endmodule : cpu_system_mode_stack_regs

`default_nettype wire

// ---- testbench/mode_stack_monitor.sv ----
/* assertions for the system register group.
   assumes it is bound to cpu_system_mode_stack_regs and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mode_stack_monitor import cpu_sys_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic set_page_in,
  input wire logic [5:0] page_in,
  input wire logic [5:0] page_select_out,
  input wire logic [3:0] stack_op_in,
  input wire logic stack_busy_out,
  input wire logic stack_done_out,
  input wire logic mem_we_out,
  input wire logic mem_re_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic bus_request_pin_in,
  input wire logic bus_request_enable_out,
  input wire logic bus_request_out,
  input wire logic bus_float_enable_out,
  input wire logic [31:0] ext_mem_line_mask_in,
  input wire logic [31:0] ext_line_float_out,
  input wire logic strobe_float_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // word push: two writes at falling addresses, then done
  sequence s_push_word;
    mem_we_out ##1 mem_we_out && mem_addr_out == $past(mem_addr_out) - 16'h0001
    ##1 stack_done_out;
  endsequence
  // byte pop: one read, no write at all, then done
  sequence s_pop_byte;
    mem_re_out && !mem_we_out ##1 !mem_we_out ##1 stack_done_out && !mem_we_out;
  endsequence
  property p_reset_state;
    disable iff (1'h0) rst_in |=> page_select_out == 6'h00 && !bus_float_enable_out;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_page_load;
    set_page_in |=> page_select_out == $past(page_in);
  endproperty
  a_page_load: assert property (p_page_load) else $error("page not loaded");
  property p_page_hold;
    !set_page_in && !(reg_wr_in && reg_addr_in == 8'hea) |=> $stable(page_select_out);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page changed");
  property p_page_low_zero;
    reg_rd_in && reg_addr_in == 8'hea |=> reg_rdata_out[1:0] == 2'h0;
  endproperty
  a_page_low_zero: assert property (p_page_low_zero) else $error("page low bits set");
  property p_bus_request;
    bus_request_out == $past(bus_request_pin_in && bus_request_enable_out);
  endproperty
  a_bus_request: assert property (p_bus_request) else $error("bus request gating");
  property p_line_float;
    ext_line_float_out == $past(ext_mem_line_mask_in & {32{bus_float_enable_out}});
  endproperty
  a_line_float: assert property (p_line_float) else $error("line float wrong");
  property p_strobe_float;
    strobe_float_out == $past(bus_float_enable_out);
  endproperty
  a_strobe_float: assert property (p_strobe_float) else $error("strobe float wrong");
  property p_push_word;
    stack_op_in == OP_PUSH_WORD && !stack_busy_out |=> ##1 s_push_word;
  endproperty
  a_push_word: assert property (p_push_word) else $error("push word sequence");
  property p_pop_byte;
    stack_op_in == OP_POP_BYTE && !stack_busy_out |=> ##1 s_pop_byte;
  endproperty
  a_pop_byte: assert property (p_pop_byte) else $error("pop wrote memory");
endmodule : mode_stack_monitor
bind cpu_system_mode_stack_regs mode_stack_monitor mon (.*);
`default_nettype wire

// ---- testbench/tb_cpu_system_mode_stack_regs.sv ----
/* self-checking bench for the system register group.
   assumes the design package is compiled first; the bench drives every port. */
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_system_mode_stack_regs;
  import cpu_sys_pkg::*;
  logic clk_in = 1'h0, rst_in = 1'h1, reg_wr_in = 1'h0, reg_rd_in = 1'h0, set_page_in = 1'h0;
  logic stack_user_in = 1'h0, segment_push_enable_in = 1'h0, bus_request_pin_in = 1'h1;
  logic [7:0] reg_addr_in = 8'h0, reg_wdata_in = 8'h0, flags_in = 8'h5a, mem_rdata_in;
  logic [5:0] page_in = 6'h0, page_select_out;
  logic [3:0] stack_op_in = 4'h0;
  logic [15:0] push_data_in = 16'hbeef, pc_in = 16'h1234, virt_addr_in = 16'hc123;
  logic [1:0] access_kind_in = 2'h0;
  logic [31:0] ext_mem_line_mask_in = 32'h0000ff0f, pop_data_out, ext_line_float_out;
  logic [7:0] reg_rdata_out, mem_wdata_out, mem [256];
  logic [15:0] mem_addr_out;
  logic [2:0] clock_prescale_field_out;
  logic [21:0] phys_addr_out;
  logic mem_we_out, mem_re_out, stack_internal_out, stack_busy_out, stack_done_out;
  logic system_stack_internal_sel_out, user_stack_internal_sel_out, osc_halve_enable_out;
  logic bus_request_enable_out, bus_float_enable_out, bus_request_out, strobe_float_out;
  logic internal_cpu_clock_en_out;
  int num_errors = 0;
  int n_compared = 0;
  cpu_system_mode_stack_regs dut (.*);
  always #10 clk_in = ~clk_in;
  // byte-wide stack memory, read combinationally
  assign mem_rdata_in = mem[mem_addr_out[7:0]];
  always @(posedge clk_in) if (mem_we_out) mem[mem_addr_out[7:0]] <= mem_wdata_out;
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(negedge clk_in);
    reg_wr_in = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(negedge clk_in);
    reg_rd_in = 1'h0;
    chk(reg_rdata_out, e);
  endtask : rd
  // issue one stack operation and wait for its done pulse
  task automatic op(input logic [3:0] c);
    @(negedge clk_in);
    stack_op_in = c;
    @(negedge clk_in);
    stack_op_in = 4'h0;
    repeat (20) if (stack_done_out !== 1'h1) @(negedge clk_in);
    chk(stack_done_out, 1'h1);
  endtask : op
  initial begin
    int en;
    repeat (12) @(negedge clk_in);
    rst_in = 1'h0;
    rd(8'heb, 8'he0);
    rd(8'hea, 8'h00);
    wr(8'hea, 8'h57);
    rd(8'hea, 8'h54);
    wr(8'hf3, 8'h9a);
    wr(8'hf4, 8'h2d);
    page_in = 6'h2a;
    set_page_in = 1'h1;
    @(negedge clk_in);
    set_page_in = 1'h0;
    rd(8'hea, 8'ha8);
    chk(phys_addr_out, 32'h268123);
    wr(8'heb, 8'h83);
    rd(8'heb, 8'h83);
    chk({system_stack_internal_sel_out, user_stack_internal_sel_out, osc_halve_enable_out,
         clock_prescale_field_out, bus_request_enable_out, bus_float_enable_out}, 8'h83);
    chk({bus_request_out, strobe_float_out, internal_cpu_clock_en_out}, 3'h7);
    chk(ext_line_float_out, ext_mem_line_mask_in);
    wr(8'hee, 8'h01);
    wr(8'hef, 8'he0);
    op(OP_PUSH_BYTE);
    chk(mem[8'hdf], 8'hef);
    rd(8'hee, 8'h01);
    rd(8'hef, 8'hdf);
    op(OP_POP_BYTE);
    chk(pop_data_out[7:0], 8'hef);
    wr(8'heb, 8'h03);
    wr(8'hef, 8'h00);
    op(OP_PUSH_WORD);
    chk({mem[8'hfe], mem[8'hff]}, 16'hbeef);
    op(OP_POP_WORD);
    chk(pop_data_out[15:0], 16'hbeef);
    chk(mem[8'hfe], 8'hbe);
    rd(8'hef, 8'h00);
    op(OP_CALL);
    op(OP_RET);
    chk(pop_data_out[15:0], pc_in);
    op(OP_INTR);
    op(OP_IRET);
    chk(pop_data_out[23:0], {flags_in, pc_in});
    op(OP_CALL_SEG);
    op(OP_RET_SEG);
    chk(pop_data_out[23:0], {pc_in, 8'h2d});
    wr(8'heb, 8'h1c);
    access_kind_in = 2'h1;
    repeat (20) @(negedge clk_in);
    en = 0;
    repeat (16) begin
      @(negedge clk_in);
      en += internal_cpu_clock_en_out;
    end
    chk(en, 32'h2);
    chk(page_select_out, 6'h2a);
    chk(phys_addr_out, 32'h2dc123);
    give_verdict();
  end
  // watchdog against a hung sequencer
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule : tb_cpu_system_mode_stack_regs
`default_nettype wire
